// file: src/tds_top.sv
/*
 * trigger delay scheduler: event edges, delay counter, comparators,
 * trigger pulses, converter command sequencing, interrupts, registers.
 * assumes an avalon-mm master, on-chip converters on the same clock
 * and asynchronous event pins.
 */
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
module tds_top
   import tds_pkg::*;
(
   // clock and reset
   input  wire logic              clock,
   input  wire logic              rst_n,
   // avalon-mm slave
   input  wire logic [7:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   // event pins
   input  wire logic [NUM_EV-1:0] event_in,
   // trigger outputs
   output logic [NUM_TRIG-1:0]    trig_pulse,
   // converter command port
   output logic [CMD_W-1:0]       conv_cmd,
   output logic                   conv_cmd_valid,
   input  wire logic [1:0]        conv_done,
   // interrupt
   output logic                   irq
);
   // ==========================================================
   // registers
   logic                 wait_ff, nxt_wait;
   logic [31:0]          rdata_ff, nxt_rdata;
   logic [4:0]           ctrl_ff, nxt_ctrl;
   logic [2*NUM_EV-1:0]  edge_ff, nxt_edge;
   logic [NUM_EV-1:0]    reload_ff, nxt_reload;
   logic [15:0]          tcfg_ff, nxt_tcfg;
   logic [9:0]           status_ff, nxt_status;
   logic [9:0]           int_en_ff, nxt_int_en;
   logic                 irq_ff, nxt_irq;
   logic [CNT_W-1:0]     cnt_ff, nxt_cnt;
   logic                 run_ff, nxt_run;
   logic [NUM_TRIG-1:0]  pulse_ff, nxt_pulse;
   logic [CNT_W-1:0]     delay_ff [NUM_TRIG];
   logic [CNT_W-1:0]     nxt_delay [NUM_TRIG];
   logic [7:0]           scfg_ff [NUM_TRIG];
   logic [7:0]           nxt_scfg [NUM_TRIG];
   logic [CMD_W-1:0]     cmd_ff [NUM_CMD];
   logic [CMD_W-1:0]     nxt_cmd [NUM_CMD];

   // ==========================================================
   // combinational terms
   logic [NUM_EV-1:0]    ev_pulse;
   logic                 enable, seq_mode;
   logic [2:0]           seq_sel;
   logic                 reload;
   logic [NUM_TRIG-1:0]  fire;
   logic [NUM_TRIG-1:0]  cmd_fire;
   logic                 wr;
   logic [31:0]          rd_mux;
   logic [9:0]           set_mask, clr_mask;
   logic [3:0]           pick;
   logic                 multi_fire;

   tds_seq_if seq_link ();

   tds_edge_detect u_edge
   (
      .clock    (clock),
      .rst_n    (rst_n),
      .event_in (event_in),
      .edge_sel (edge_ff),
      .ev_pulse (ev_pulse)
   );

   tds_cmd_seq u_seq
   (
      .clock     (clock),
      .rst_n     (rst_n),
      .ctl       (seq_link.seq),
      .cmd_data  (conv_cmd),
      .cmd_valid (conv_cmd_valid),
      .conv_done (conv_done)
   );

   // ==========================================================
   // counter, comparators and trigger selection
   assign enable   = ctrl_ff[CTRL_EN_BIT];
   assign seq_mode = ctrl_ff[CTRL_MODE_BIT];
   assign seq_sel  = ctrl_ff[CTRL_SEL_LSB +: 3];

   always_comb
   begin
      if (seq_mode)
         reload = enable && (ev_pulse[0] || ev_pulse[seq_sel]);
      else
         reload = enable && ((ev_pulse & reload_ff) != '0);
      for (int i = 0; i < NUM_TRIG; i++)
      begin
         if (seq_mode)
            fire[i] = enable && run_ff && (i == int'(seq_sel))
                   && (cnt_ff == delay_ff[0]);
         else
            fire[i] = enable && run_ff && (cnt_ff == delay_ff[i]);
      end
      cmd_fire   = fire & tcfg_ff[TCFG_CMD_LSB +: NUM_TRIG];
      multi_fire = (cmd_fire & (cmd_fire - 8'h01)) != 8'h00;
      pick       = 4'h0;
      for (int i = NUM_TRIG - 1; i >= 0; i--)
      begin
         if (cmd_fire[i])
            pick = 4'(i);
      end
   end

   // lowest firing trigger owns the sequencer
   assign seq_link.start = (cmd_fire != '0) && !seq_link.busy
                        && (scfg_ff[pick[2:0]][SCFG_CNT_LSB +: 4] != 4'h0);
   assign seq_link.first = scfg_ff[pick[2:0]][SCFG_FIRST_LSB +: 4];
   assign seq_link.count = scfg_ff[pick[2:0]][SCFG_CNT_LSB +: 4];
   assign seq_link.tbl_data = cmd_ff[seq_link.tbl_addr];

   // ==========================================================
   // register read mux
   always_comb
   begin
      rd_mux = RST_WORD;
      if (avs_address >= OFS_CMD)
         rd_mux[CMD_USED_W-1:0] = cmd_ff[avs_address[5:2]][CMD_USED_W-1:0];
      else if (avs_address >= OFS_SCFG && avs_address < 8'h60)
         rd_mux[7:0] = scfg_ff[avs_address[4:2]];
      else if (avs_address >= OFS_DELAY && avs_address < OFS_SCFG)
         rd_mux[CNT_W-1:0] = delay_ff[avs_address[4:2]];
      else
         case (avs_address)
            OFS_CTRL:   rd_mux[4:0]  = ctrl_ff;
            OFS_EDGE:   rd_mux[15:0] = edge_ff;
            OFS_RELOAD: rd_mux[7:0]  = reload_ff;
            OFS_TCFG:   rd_mux[15:0] = tcfg_ff;
            OFS_STATUS: rd_mux[9:0]  = status_ff;
            OFS_INT_EN: rd_mux[9:0]  = int_en_ff;
            OFS_COUNT:
            begin
               rd_mux[CNT_W-1:0]     = cnt_ff;
               rd_mux[COUNT_RUN_BIT]  = run_ff;
               rd_mux[COUNT_BUSY_BIT] = seq_link.busy;
            end
            default:    rd_mux = RST_WORD;
         endcase
   end

   // ==========================================================
   // next state
   always_comb
   begin
      nxt_wait   = 1'b1;
      nxt_rdata  = rdata_ff;
      nxt_ctrl   = ctrl_ff;
      nxt_edge   = edge_ff;
      nxt_reload = reload_ff;
      nxt_tcfg   = tcfg_ff;
      nxt_int_en = int_en_ff;
      nxt_delay  = delay_ff;
      nxt_scfg   = scfg_ff;
      nxt_cmd    = cmd_ff;
      clr_mask   = 10'h000;
      // one wait cycle, then the request is answered
      if ((avs_read || avs_write) && wait_ff)
      begin
         nxt_wait  = 1'b0;
         nxt_rdata = rd_mux;
      end
      wr = avs_write && !wait_ff;
      if (wr)
      begin
         if (avs_address >= OFS_CMD)
            nxt_cmd[avs_address[5:2]] = avs_writedata[CMD_W-1:0];
         else if (avs_address >= OFS_SCFG && avs_address < 8'h60)
            nxt_scfg[avs_address[4:2]] = avs_writedata[7:0];
         else if (avs_address >= OFS_DELAY && avs_address < OFS_SCFG)
            nxt_delay[avs_address[4:2]] = avs_writedata[CNT_W-1:0];
         else
            case (avs_address)
               OFS_CTRL:    nxt_ctrl   = avs_writedata[4:0];
               OFS_EDGE:    nxt_edge   = avs_writedata[15:0];
               OFS_RELOAD:  nxt_reload = avs_writedata[7:0];
               OFS_TCFG:    nxt_tcfg   = avs_writedata[15:0];
               OFS_INT_CLR: clr_mask   = avs_writedata[9:0];
               OFS_INT_EN:  nxt_int_en = avs_writedata[9:0];
               default:     clr_mask   = 10'h000;
            endcase
      end
      // status: set wins over clear
      set_mask = {seq_link.done,
                  (cmd_fire != '0) && (seq_link.busy || multi_fire),
                  fire};
      nxt_status = (status_ff & ~clr_mask) | set_mask;
      nxt_irq    = (nxt_status & int_en_ff) != 10'h000;
      nxt_pulse  = fire & tcfg_ff[TCFG_PULSE_LSB +: NUM_TRIG];
      // counter restarts from zero and stops at its end
      nxt_cnt = cnt_ff;
      nxt_run = run_ff && enable;
      if (reload)
      begin
         nxt_cnt = RST_WORD[CNT_W-1:0];
         nxt_run = 1'b1;
      end
      else if (run_ff)
      begin
         if (cnt_ff == CNT_MAX)
            nxt_run = 1'b0;
         else
            nxt_cnt = cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_ff   <= 1'b1;
         rdata_ff  <= RST_WORD;
         ctrl_ff   <= RST_WORD[4:0];
         edge_ff   <= RST_WORD[15:0];
         reload_ff <= RST_WORD[7:0];
         tcfg_ff   <= RST_WORD[15:0];
         status_ff <= RST_WORD[9:0];
         int_en_ff <= RST_WORD[9:0];
         irq_ff    <= 1'b0;
         cnt_ff    <= RST_WORD[CNT_W-1:0];
         run_ff    <= 1'b0;
         pulse_ff  <= RST_WORD[7:0];
         for (int i = 0; i < NUM_TRIG; i++)
         begin
            delay_ff[i] <= RST_WORD[CNT_W-1:0];
            scfg_ff[i]  <= RST_WORD[7:0];
         end
         for (int i = 0; i < NUM_CMD; i++)
            cmd_ff[i] <= RST_WORD[CMD_W-1:0];
      end
      else
      begin
         wait_ff   <= nxt_wait;
         rdata_ff  <= nxt_rdata;
         ctrl_ff   <= nxt_ctrl;
         edge_ff   <= nxt_edge;
         reload_ff <= nxt_reload;
         tcfg_ff   <= nxt_tcfg;
         status_ff <= nxt_status;
         int_en_ff <= nxt_int_en;
         irq_ff    <= nxt_irq;
         cnt_ff    <= nxt_cnt;
         run_ff    <= nxt_run;
         pulse_ff  <= nxt_pulse;
         delay_ff  <= nxt_delay;
         scfg_ff   <= nxt_scfg;
         cmd_ff    <= nxt_cmd;
      end
   end

   assign avs_readdata    = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign trig_pulse      = pulse_ff;
   assign irq             = irq_ff;

   // ==========================================================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_reload_zero:
      assert property (reload |=> cnt_ff == 16'h0000 && run_ff)
      else $error("counter not restarted on reload");

   a_count_step:
      assert property (run_ff && enable && !reload && cnt_ff == 16'h0000
         ##1 (!reload && enable) [*3] |=> cnt_ff == 16'h0004)
      else $error("counter did not advance one per clock");

   a_comp_fire:
      assert property (!seq_mode && enable && run_ff
         && cnt_ff == delay_ff[1] && tcfg_ff[1] |=> trig_pulse[1])
      else $error("comparator match without trigger pulse");

   a_seq_one:
      assert property (seq_mode |-> (fire & ~(8'h01 << seq_sel)) == 8'h00)
      else $error("sequential mode fired an unselected trigger");

   a_pulse_cause:
      assert property (trig_pulse[0] |-> $past(fire[0] && tcfg_ff[0]))
      else $error("trigger pulse without its comparator");

   a_irq_level:
      assert property (##1 irq == ($past(nxt_status & int_en_ff) != 10'h000))
      else $error("interrupt does not follow enabled status");

   a_overrun_set:
      assert property ((cmd_fire != '0) && seq_link.busy
         |=> status_ff[STAT_OVR_BIT])
      else $error("overrun not flagged");

   a_bus_answer:
      assert property ((avs_read || avs_write) && wait_ff
         |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle after request");
endmodule

// file: src/tds_pkg.sv
/*
 * constants, register map and types of the trigger delay scheduler.
 * assumes a 32-bit avalon-mm slave port with byte addresses.
 */
package tds_pkg;
   // ==========================================================
   // sizes
   localparam int NUM_EV   = 8;
   localparam int NUM_TRIG = 8;
   localparam int NUM_CMD  = 16;
   localparam int CNT_W    = 16;
   localparam int CMD_W    = 16;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_EDGE    = 8'h04;
   localparam logic [7:0] OFS_RELOAD  = 8'h08;
   localparam logic [7:0] OFS_TCFG    = 8'h0C;
   localparam logic [7:0] OFS_STATUS  = 8'h10;
   localparam logic [7:0] OFS_INT_CLR = 8'h14;
   localparam logic [7:0] OFS_INT_EN  = 8'h18;
   localparam logic [7:0] OFS_COUNT   = 8'h1C;
   localparam logic [7:0] OFS_DELAY   = 8'h20;
   localparam logic [7:0] OFS_SCFG    = 8'h40;
   localparam logic [7:0] OFS_CMD     = 8'h80;

   // ==========================================================
   // field positions
   localparam int CTRL_EN_BIT    = 0;
   localparam int CTRL_MODE_BIT  = 1;
   localparam int CTRL_SEL_LSB   = 2;
   localparam int EDGE_RISE_BIT  = 0;
   localparam int EDGE_FALL_BIT  = 1;
   localparam int TCFG_PULSE_LSB = 0;
   localparam int TCFG_CMD_LSB   = 8;
   localparam int STAT_OVR_BIT   = 8;
   localparam int STAT_DONE_BIT  = 9;
   localparam int COUNT_RUN_BIT  = 16;
   localparam int COUNT_BUSY_BIT = 17;
   localparam int SCFG_FIRST_LSB = 0;
   localparam int SCFG_CNT_LSB   = 4;
   localparam int CMD_CH_LSB     = 0;
   localparam int CMD_CONV_BIT   = 6;
   localparam int CMD_DUAL_BIT   = 7;
   localparam int CMD_BUF_LSB    = 8;
   localparam int CMD_USED_W     = 11;

   // ==========================================================
   // reset values
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;
   localparam logic [31:0] ALL_ONES  = 32'hFFFF_FFFF;

   // ==========================================================
   // command sequencer states
   typedef enum logic [1:0]
   {
      SEQ_IDLE  = 2'b00,
      SEQ_ISSUE = 2'b01,
      SEQ_WAIT  = 2'b10
   } tds_seq_state_e;
endpackage

// file: src/tds_seq_if.sv
/*
 * link between the scheduler core and its command sequencer.
 * assumes both ends share one clock.
 */
`timescale 1ns/100ps
interface tds_seq_if
   import tds_pkg::*;
();
   logic             start;
   logic [3:0]       first;
   logic [3:0]       count;
   logic [3:0]       tbl_addr;
   logic [CMD_W-1:0] tbl_data;
   logic             busy;
   logic             done;

   modport ctl
   (
      output start, first, count, tbl_data,
      input  tbl_addr, busy, done
   );
   modport seq
   (
      input  start, first, count, tbl_data,
      output tbl_addr, busy, done
   );
endinterface

// file: src/tds_edge_detect.sv
/*
 * synchronises the event pins and detects the selected edges.
 * assumes event pins are asynchronous to clock.
 */
`timescale 1ns/100ps
module tds_edge_detect
   import tds_pkg::*;
(
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   // pins and selection
   input  wire logic [NUM_EV-1:0]     event_in,
   input  wire logic [2*NUM_EV-1:0]   edge_sel,
   // detected events
   output logic      [NUM_EV-1:0]     ev_pulse
);
   // ==========================================================
   // per event synchroniser and edge detector
   for (genvar i = 0; i < NUM_EV; i++)
   begin : g_ev
      logic sync1_ff, sync2_ff, prev_ff, pulse_ff;
      logic nxt_pulse;

      always_comb
      begin
         nxt_pulse = (edge_sel[2*i+EDGE_RISE_BIT] && sync2_ff && !prev_ff)
            || (edge_sel[2*i+EDGE_FALL_BIT] && !sync2_ff && prev_ff);
      end

      always_ff @(posedge clock or negedge rst_n)
      begin
         if (!rst_n)
         begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
            pulse_ff <= 1'b0;
         end
         else
         begin
            sync1_ff <= event_in[i];
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
            pulse_ff <= nxt_pulse;
         end
      end

      assign ev_pulse[i] = pulse_ff;

      a_edge_off:
         assert property (@(posedge clock) disable iff (!rst_n)
            (edge_sel[2*i+1 -: 2] == 2'b00) |=> !ev_pulse[i])
         else $error("edge pulse with detection disabled");
   end
endmodule

// file: src/tds_cmd_seq.sv
/*
 * issues the queued converter commands of one trigger, one at a time.
 * assumes converter done pulses arrive on the same clock.
 */
`timescale 1ns/100ps
module tds_cmd_seq
   import tds_pkg::*;
(
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // core side
   tds_seq_if.seq                ctl,
   // converter side
   output logic      [CMD_W-1:0] cmd_data,
   output logic                  cmd_valid,
   input  wire logic [1:0]       conv_done
);
   // ==========================================================
   // state
   tds_seq_state_e   state_ff, nxt_state;
   logic [3:0]       idx_ff, nxt_idx;
   logic [3:0]       left_ff, nxt_left;
   logic [1:0]       got_ff, nxt_got;
   logic [1:0]       need_ff, nxt_need;
   logic             valid_ff, nxt_valid;
   logic [CMD_W-1:0] data_ff, nxt_data;
   logic             done_ff, nxt_done;
   logic [1:0]       got_now;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_idx   = idx_ff;
      nxt_left  = left_ff;
      nxt_got   = got_ff;
      nxt_need  = need_ff;
      nxt_data  = data_ff;
      nxt_valid = 1'b0;
      nxt_done  = 1'b0;
      got_now   = got_ff | conv_done;
      case (state_ff)
         SEQ_IDLE:
         begin
            if (ctl.start)
            begin
               nxt_idx   = ctl.first;
               nxt_left  = ctl.count;
               nxt_state = SEQ_ISSUE;
            end
         end
         SEQ_ISSUE:
         begin
            nxt_valid = 1'b1;
            nxt_data  = ctl.tbl_data;
            nxt_got   = 2'b00;
            // a concurrent command waits for both converters
            if (ctl.tbl_data[CMD_DUAL_BIT])
               nxt_need = 2'b11;
            else if (ctl.tbl_data[CMD_CONV_BIT])
               nxt_need = 2'b10;
            else
               nxt_need = 2'b01;
            nxt_state = SEQ_WAIT;
         end
         SEQ_WAIT:
         begin
            nxt_got = got_now;
            if ((got_now & need_ff) == need_ff)
            begin
               if (left_ff == 4'h1)
               begin
                  nxt_done  = 1'b1;
                  nxt_state = SEQ_IDLE;
               end
               else
               begin
                  nxt_idx   = idx_ff + 4'h1;
                  nxt_left  = left_ff - 4'h1;
                  nxt_state = SEQ_ISSUE;
               end
            end
         end
         default:
            nxt_state = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= SEQ_IDLE;
         idx_ff   <= 4'h0;
         left_ff  <= 4'h0;
         got_ff   <= 2'b00;
         need_ff  <= 2'b00;
         valid_ff <= 1'b0;
         data_ff  <= RST_WORD[CMD_W-1:0];
         done_ff  <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         idx_ff   <= nxt_idx;
         left_ff  <= nxt_left;
         got_ff   <= nxt_got;
         need_ff  <= nxt_need;
         valid_ff <= nxt_valid;
         data_ff  <= nxt_data;
         done_ff  <= nxt_done;
      end
   end

   assign cmd_valid    = valid_ff;
   assign cmd_data     = data_ff;
   assign ctl.tbl_addr = idx_ff;
   assign ctl.busy     = (state_ff != SEQ_IDLE);
   assign ctl.done     = done_ff;

   // ==========================================================
   // checks
   a_wait_done:
      assert property (@(posedge clock) disable iff (!rst_n)
         (state_ff == SEQ_WAIT && ((got_now & need_ff) != need_ff))
         |=> !cmd_valid && state_ff == SEQ_WAIT)
      else $error("command issued before completion");

   a_dual_both:
      assert property (@(posedge clock) disable iff (!rst_n)
         (state_ff == SEQ_WAIT && need_ff == 2'b11 && got_now == 2'b01)
         |=> state_ff == SEQ_WAIT)
      else $error("concurrent command ended on one converter");

   a_cmd_queue:
      assert property (@(posedge clock) disable iff (!rst_n)
         (state_ff == SEQ_WAIT && left_ff > 4'h1
          && ((got_now & need_ff) == need_ff))
         |=> ##1 cmd_valid && ctl.tbl_addr == $past(idx_ff, 2) + 4'h1)
      else $error("queued command not issued next");
endmodule

// file: verification/tds_conv_model.sv
/*
 * converter model: takes commands, answers with done pulses.
 * assumes one clock shared with the scheduler.
 */
`timescale 1ns/100ps
module tds_conv_model
   import tds_pkg::*;
(
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // command side
   input  wire logic [CMD_W-1:0] conv_cmd,
   input  wire logic             conv_cmd_valid,
   input  wire logic [7:0]       lat,
   output logic      [1:0]       conv_done
);
   // ==========================================================
   // conversion timing
   logic [7:0] cnt_ff;
   logic [1:0] pend_ff;
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_ff    <= 8'h00;
         pend_ff   <= 2'h0;
         conv_done <= 2'h0;
      end
      else
      begin
         conv_done <= 2'h0;
         if (conv_cmd_valid)
         begin
            cnt_ff  <= lat;
            pend_ff <= conv_cmd[CMD_DUAL_BIT] ? 2'h3 :
                       (conv_cmd[CMD_CONV_BIT] ? 2'h2 : 2'h1);
         end
         else if (pend_ff != 2'h0 && cnt_ff == 8'h00)
         begin
            // a concurrent pair answers converter 0 first, then converter 1
            conv_done <= (pend_ff == 2'h3) ? 2'h1 : pend_ff;
            pend_ff   <= (pend_ff == 2'h3) ? 2'h2 : 2'h0;
         end
         else if (cnt_ff != 8'h00)
            cnt_ff <= cnt_ff - 8'h01;
      end
   end
endmodule

// file: verification/tb_top.sv
/*
 * self-checking bench of the trigger delay scheduler.
 * assumes the converter model and the avalon-mm slave of tds_top.
 */
`timescale 1ns/100ps
module tb_top
   import tds_pkg::*;
;
   logic        clock, rst_n, avs_read, avs_write, avs_waitrequest;
   logic        conv_cmd_valid, irq;
   logic [7:0]  avs_address, lat, event_in, trig_pulse;
   logic [31:0] avs_writedata, avs_readdata, rv;
   logic [15:0] conv_cmd;
   logic [1:0]  conv_done;
   int          n_fail, compares, cyc, ev_t, t0;
   int          tp[8], np[8], tv[$], td[$];
   logic [15:0] cq[$];
   int          eb[6] = '{0, 0, 1, 1, 2, 2};
   logic        evv[6] = '{1, 0, 1, 0, 1, 0};
   int          ee[6] = '{1, 1, 1, 2, 3, 4};

   tds_top tds_top_i (.clock(clock), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .event_in(event_in), .trig_pulse(trig_pulse), .conv_cmd(conv_cmd),
      .conv_cmd_valid(conv_cmd_valid), .conv_done(conv_done), .irq(irq));
   tds_conv_model tds_conv_model_i (.clock(clock), .rst_n(rst_n),
      .conv_cmd(conv_cmd), .conv_cmd_valid(conv_cmd_valid), .lat(lat),
      .conv_done(conv_done));

   // ==========================================================
   // clock and port monitor
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      for (int i = 0; i < 8; i++)
         if (trig_pulse[i] === 1'b1)
         begin
            tp[i] = cyc;
            np[i]++;
         end
      if (conv_cmd_valid === 1'b1)
      begin
         tv.push_back(cyc);
         cq.push_back(conv_cmd);
      end
      if (conv_done !== 2'h0)
         td.push_back(cyc);
   end

   // ==========================================================
   // tasks
   task automatic chk(input string nm, input logic [31:0] s, e);
      compares++;
      if (s !== e)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= 1'b1;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a);
      avs_address <= a;
      avs_read    <= 1'b1;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rv = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk("register", rv, e);
   endtask
   task automatic ev(input int b, input logic v, input int n);
      event_in[b] <= v;
      ev_t = cyc;
      repeat (n) @(posedge clock);
   endtask
   task automatic ic(input logic e);
      repeat (2) @(posedge clock);
      chk("irq", irq, e);
   endtask
   task automatic close_out();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ==========================================================
   // watchdog
   initial
   begin
      repeat (20000) @(posedge clock);
      n_fail++;
      close_out();
   end

   // ==========================================================
   // tests
   initial
   begin
      {rst_n, avs_read, avs_write, avs_address} = 11'h000;
      {avs_writedata, event_in, lat} = 48'h0000_0000_0006;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      rc(OFS_COUNT, RST_WORD);
      rc(OFS_STATUS, RST_WORD);
      rc(8'h60, RST_WORD);
      wr(OFS_EDGE, 32'h0000_0039);
      wr(OFS_RELOAD, 32'h0000_0007);
      wr(OFS_DELAY, 32'h0000_0004);
      wr(OFS_DELAY + 8'h04, 32'h0000_000A);
      wr(OFS_DELAY + 8'h1C, 32'h0000_0014);
      wr(OFS_TCFG, 32'h0000_0083);
      wr(OFS_INT_EN, 32'h0000_0001);
      wr(OFS_CTRL, 32'h0000_0001);
      for (int k = 0; k < 6; k++)
      begin
         ev(eb[k], evv[k], 50);
         chk("reloads", np[0], ee[k]);
      end
      chk("fires7", np[7], 4);
      chk("gap1", tp[1] - tp[0], 6);
      chk("gap7", tp[7] - tp[0], 16);
      chk("fires2", np[2], 0);
      t0 = tp[0] - ev_t;
      ic(1'b1);
      wr(OFS_INT_EN, RST_WORD);
      ic(1'b0);
      wr(OFS_INT_EN, 32'h0000_0001);
      ic(1'b1);
      wr(OFS_INT_CLR, ALL_ONES);
      ic(1'b0);
      // two queued commands, the second concurrent
      wr(OFS_CMD, 32'h0000_0245);
      wr(OFS_CMD + 8'h04, 32'h0000_03C9);
      wr(OFS_SCFG, 32'h0000_0020);
      wr(OFS_TCFG, 32'h0000_0183);
      ev(0, 1'b1, 80);
      chk("cmds", cq.size(), 2);
      chk("cmd0", cq[0], 16'h0245);
      chk("cmd1", cq[1], 16'h03C9);
      chk("lag", tv[0] - tp[0], 1);
      chk("wait", tv[1] - td[0], 2);
      rd(OFS_STATUS);
      chk("done", rv[STAT_DONE_BIT], 1'b1);
      // second trigger while a slow sequence is busy
      lat <= 8'h3C;
      wr(OFS_INT_CLR, ALL_ONES);
      ev(2, 1'b1, 30);
      ev(2, 1'b0, 200);
      rd(OFS_STATUS);
      chk("overrun", rv[STAT_OVR_BIT], 1'b1);
      wr(OFS_TCFG, 32'h0000_0009);
      wr(OFS_EDGE, 32'h0000_0079);
      wr(OFS_CTRL, 32'h0000_000F);
      ev(3, 1'b1, 50);
      chk("seqlag", tp[3] - ev_t, t0);
      chk("seqonly", np[0], 7);
      close_out();
   end
endmodule
